// ==== design/tocmp_channel.sv ====
// Output compare channel of a 16-bit timer with APB register access
`timescale 1ns/1ps
`include "tocmp_params.svh"

module tocmp_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] timer_count,
  input wire logic timer_tick,
  input wire logic count_write,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic count_down,
  input wire logic irq_ack,
  output logic irq,
  output logic match_top,
  output logic match_top_en,
  output logic waveform_out_state,
  output logic pin_out,
  output logic pin_oe
);

  // ========================================================================
  // Register state. Everything below but wr_state_ff (idle, 2'b01) resets to zero, which leaves the pin
  // on its port latch, the direction at input and the flag quiet until
  // software has set the channel up.
  // The staging byte is shared by both compare paths, so a high write that
  // is never followed by a low write lingers harmlessly until the next
  // pair overwrites it.
  logic [3:0] waveform_mode_sel_ff;
  logic [1:0] output_action_sel_ff;
  logic match_irq_enable_ff;
  logic port_latch_ff;
  logic waveform_pin_direction_ff;
  logic top_src_ff;
  logic [15:0] match_value_ff;
  logic [15:0] match_buffer_ff;
  logic [7:0] staging_ff;
  tocmp_pkg::tocmp_wr_t wr_state_ff;
  logic match_flag_ff;
  logic waveform_out_state_ff;
  logic block_ff;
  logic match_pend_ff;
  logic [31:0] prdata_ff;

  // Merge a byte into the upper half of a 16-bit value; used both for the
  // staged commit and for an unpaired low write, which pairs with zero.
  function automatic logic [15:0] join_bytes(input logic [7:0] hi,
                                             input logic [7:0] lo);
    join_bytes = {hi, lo};
  endfunction

  // Apply a non-PWM match action to the output state. A real match and a
  // forced one share this, so the two paths can never drift apart.
  function automatic logic next_out(input logic [1:0] act,
                                    input logic cur);
    case (act)
      2'h1: next_out = ~cur;
      2'h2: next_out = 1'b0;
      2'h3: next_out = 1'b1;
      default: next_out = cur;
    endcase
  endfunction

  // ========================================================================
  // Mode decode: Normal (0) and the two clear-on-match modes are non-PWM
  // Every other code is a PWM mode and switches the compare buffer on.
  // The fast modes count in one slope, so their buffer moves at BOTTOM;
  // the dual-slope modes move it at TOP, where the pulse is centred.
  // Unused codes fall into the PWM group, the safer of the two choices.
  wire is_pwm;
  wire is_fast;
  assign is_pwm = (waveform_mode_sel_ff != `TOCMP_RST_MODE) &&
                  (waveform_mode_sel_ff != `TOCMP_MODE_CTC_A) &&
                  (waveform_mode_sel_ff != `TOCMP_MODE_CTC_ICR);
  assign is_fast = (waveform_mode_sel_ff == 4'h5) ||
                   (waveform_mode_sel_ff == 4'h6) ||
                   (waveform_mode_sel_ff == 4'h7) ||
                   (waveform_mode_sel_ff == 4'he) ||
                   (waveform_mode_sel_ff == 4'hf);

  // ========================================================================
  // APB decode; single-cycle answer, unmapped addresses give an error
  // Only whole-word offsets are mapped. An access while clk_en is low
  // still sees pready high but changes nothing, so software must avoid it.
  // Read data is captured in the setup cycle and stands through access,
  // which keeps the read path off the access-phase timing.
  wire acc;
  wire wr;
  wire rd;
  wire hit_ctrl;
  wire hit_high;
  wire hit_low;
  wire hit_stat;
  wire hit_force;
  wire hit_act;
  wire hit_buf;
  wire hit_any;
  assign acc = psel && penable && clk_en;
  assign hit_ctrl = (paddr == `TOCMP_OFF_CTRL);
  assign hit_high = (paddr == `TOCMP_OFF_MATCH_HIGH);
  assign hit_low = (paddr == `TOCMP_OFF_MATCH_LOW);
  assign hit_stat = (paddr == `TOCMP_OFF_STATUS);
  assign hit_force = (paddr == `TOCMP_OFF_FORCE);
  assign hit_act = (paddr == `TOCMP_OFF_ACTIVE);
  assign hit_buf = (paddr == `TOCMP_OFF_BUFFER);
  assign hit_any = hit_ctrl || hit_high || hit_low || hit_stat ||
                   hit_force || hit_act || hit_buf;
  assign wr = acc && pwrite && hit_any;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ========================================================================
  // Comparator and match qualification
  // The raw comparator runs on every system clock, but a match only counts
  // on a timer tick. The TOP indication honours the same blocking window,
  // so a counter written equal to the compare value is not cut short.
  // A force only exists outside PWM; in PWM the strobe is dropped here.
  wire raw_match;
  wire timer_match;
  wire force_hit;
  wire low_commit;
  wire [15:0] new_value;
  wire buf_load;
  assign raw_match = (timer_count == match_value_ff);
  // Blocking lasts one timer tick after any counter write
  assign timer_match = raw_match && timer_tick && !block_ff;
  assign force_hit = wr && hit_force && pwdata[0] && !is_pwm;
  assign low_commit = wr && hit_low && (wr_state_ff ==
                      tocmp_pkg::tocmp_wr_staged);
  assign new_value = join_bytes(staging_ff, pwdata[7:0]);
  assign buf_load = is_pwm && timer_tick &&
                    (is_fast ? at_bottom : at_top);
  assign match_top = raw_match && !block_ff;
  assign match_top_en = top_src_ff;

  // ========================================================================
  // Control register; action used directly, no buffering
  // A new action is seen by the very next match. Buffering it with the
  // compare value would delay it to TOP or BOTTOM, which is not wanted.
  // Mode writes leave the output state alone, so a channel can be moved
  // between modes without a glitch on its pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_mode_sel_ff <= `TOCMP_RST_MODE;
      output_action_sel_ff <= `TOCMP_RST_ACT;
      match_irq_enable_ff <= 1'b0;
      port_latch_ff <= 1'b0;
      waveform_pin_direction_ff <= 1'b0;
      top_src_ff <= 1'b0;
    end else if (wr && hit_ctrl) begin
      waveform_mode_sel_ff <= pwdata[`TOCMP_CTRL_MODE_LSB +: 4];
      output_action_sel_ff <= pwdata[`TOCMP_CTRL_ACT_LSB +: 2];
      match_irq_enable_ff <= pwdata[`TOCMP_CTRL_IRQEN_BIT];
      port_latch_ff <= pwdata[`TOCMP_CTRL_PORTLATCH_BIT];
      waveform_pin_direction_ff <= pwdata[`TOCMP_CTRL_DIR_BIT];
      top_src_ff <= pwdata[`TOCMP_CTRL_TOPSRC_BIT];
    end
  end

  // ========================================================================
  // High-byte staging latch; a low write without staging uses zero
  // The latch lets a 16-bit value land in one cycle although software
  // writes it a byte at a time, so the comparator never sees a half-new
  // value. A repeated high write simply replaces the staged byte; the
  // low write closes the pair and returns the latch to idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      staging_ff <= 8'h00;
      wr_state_ff <= tocmp_pkg::tocmp_wr_idle;
    end else if (clk_en) begin
      case (wr_state_ff)
        tocmp_pkg::tocmp_wr_idle: begin
          if (wr && hit_high) begin
            staging_ff <= pwdata[7:0];
            wr_state_ff <= tocmp_pkg::tocmp_wr_staged;
          end
        end
        tocmp_pkg::tocmp_wr_staged: begin
          if (wr && hit_high) begin
            staging_ff <= pwdata[7:0];
          end else if (wr && hit_low) begin
            wr_state_ff <= tocmp_pkg::tocmp_wr_idle;
          end
        end
        default: wr_state_ff <= tocmp_pkg::tocmp_wr_idle;
      endcase
    end
  end

  // ========================================================================
  // Buffer and active compare value; hardware alters only the active one, copying the buffer
  // In PWM modes a write only reaches the buffer and the active value
  // follows at the next TOP or BOTTOM, which keeps every pulse whole.
  // Outside PWM the write goes straight to the comparator, so a value
  // below the current count is missed until the counter wraps.
  wire [15:0] written;
  assign written = low_commit ? new_value : join_bytes(8'h00, pwdata[7:0]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_buffer_ff <= `TOCMP_RST_MATCH;
    end else if (wr && hit_low && is_pwm) begin
      match_buffer_ff <= written;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_value_ff <= `TOCMP_RST_MATCH;
    end else if (wr && hit_low && !is_pwm) begin
      match_value_ff <= written;
    end else if (clk_en && buf_load) begin
      match_value_ff <= match_buffer_ff;
    end
  end

  // ========================================================================
  // Match blocking after counter write and delayed flag set
  // The block is armed by a counter write and lifted by the next tick, so
  // a compare value equal to the written count raises nothing at start.
  // The match is registered at a tick and reaches the flag one tick
  // later; a stopped timer keeps the block armed until it runs again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_ff <= 1'b0;
      match_pend_ff <= 1'b0;
    end else if (clk_en) begin
      if (count_write) begin
        block_ff <= 1'b1;
      end else if (timer_tick) begin
        block_ff <= 1'b0;
      end
      if (timer_tick) begin
        match_pend_ff <= timer_match;
      end
    end
  end

  // Flag: set one tick later; a set wins over a clear in the same cycle
  // Losing a fresh match to a clear in the same cycle would hide an event
  // from software, so the set has priority over both clear sources.
  wire flag_set;
  wire flag_clr;
  assign flag_set = match_pend_ff && timer_tick;
  assign flag_clr = (wr && hit_stat && pwdata[`TOCMP_ST_FLAG_BIT]) ||
                    irq_ack;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (flag_set) begin
        match_flag_ff <= 1'b1;
      end else if (flag_clr) begin
        match_flag_ff <= 1'b0;
      end
    end
  end
  assign irq = match_flag_ff && match_irq_enable_ff;

  // ========================================================================
  // Output state; never touched by mode writes
  // In fast PWM only the non-inverting and inverting actions drive the
  // state; toggle in PWM and the dual-slope waveforms are not modelled,
  // a known limitation. Outside PWM a real match and a forced one take
  // the same path through the action function.
  logic nxt_out;
  always_comb begin
    nxt_out = waveform_out_state_ff;
    if (is_pwm) begin
      if (is_fast && output_action_sel_ff[1]) begin
        // Non-inverting (2) clears at match, inverting (3) sets
        if (timer_match) begin
          nxt_out = output_action_sel_ff[0];
        end else if (timer_tick && at_bottom) begin
          nxt_out = ~output_action_sel_ff[0];
        end
      end
    end else if (timer_match || force_hit) begin
      nxt_out = next_out(output_action_sel_ff,
                         waveform_out_state_ff);
    end
  end

  // Output state register. It holds across mode and action changes; only
  // a match, a force, BOTTOM or reset moves it, and clk_en low freezes it
  // like every other piece of state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_out_state_ff <= 1'b0;
    end else if (clk_en) begin
      waveform_out_state_ff <= nxt_out;
    end
  end
  assign waveform_out_state = waveform_out_state_ff;

  // Pin mux: action overrides only the value, direction stays with port
  // Software should set the state up before turning the direction on;
  // with the direction bit clear the pin is never driven.
  assign pin_out = (output_action_sel_ff != 2'h0) ?
                   waveform_out_state_ff : port_latch_ff;
  assign pin_oe = waveform_pin_direction_ff;

  // ========================================================================
  // Read data; direct reads, no staging latch involved, force reads zero
  // The compare bytes read back whichever register a write reaches in the
  // current mode, straight from the flops, so reads need no byte order.
  wire [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? {22'h0, top_src_ff,
                    waveform_pin_direction_ff, port_latch_ff,
                    match_irq_enable_ff, output_action_sel_ff,
                    waveform_mode_sel_ff} :
                  hit_high ? {24'h000000, (is_pwm ? match_buffer_ff[15:8]
                    : match_value_ff[15:8])} :
                  hit_low ? {24'h000000, (is_pwm ? match_buffer_ff[7:0]
                    : match_value_ff[7:0])} :
                  hit_stat ? {29'h0, raw_match,
                    waveform_out_state_ff, match_flag_ff} :
                  hit_act ? {16'h0000, match_value_ff} :
                  hit_buf ? {16'h0000, match_buffer_ff} :
                  32'h00000000;
  // Read data register, loaded in the setup cycle of a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (clk_en && rd) begin
      prdata_ff <= rd_mux;
    end
  end
  assign prdata = prdata_ff;

endmodule

// ==== inc/tocmp_params.svh ====
// Constants of the timer output compare channel: offsets, fields, resets
`ifndef TOCMP_PARAMS_SVH
`define TOCMP_PARAMS_SVH
// ==========================================================================
// Register byte offsets on APB
`define TOCMP_OFF_CTRL 12'h000
`define TOCMP_OFF_MATCH_HIGH 12'h004
`define TOCMP_OFF_MATCH_LOW 12'h008
`define TOCMP_OFF_STATUS 12'h00c
`define TOCMP_OFF_FORCE 12'h010
`define TOCMP_OFF_ACTIVE 12'h014
`define TOCMP_OFF_BUFFER 12'h018
// ==========================================================================
// Control register fields
`define TOCMP_CTRL_MODE_LSB 0
`define TOCMP_CTRL_ACT_LSB 4
`define TOCMP_CTRL_IRQEN_BIT 6
`define TOCMP_CTRL_PORTLATCH_BIT 7
`define TOCMP_CTRL_DIR_BIT 8
`define TOCMP_CTRL_TOPSRC_BIT 9
// ==========================================================================
// Status register fields
`define TOCMP_ST_FLAG_BIT 0
`define TOCMP_ST_OUT_BIT 1
`define TOCMP_ST_MATCH_BIT 2
// ==========================================================================
// Reset values and the clear-on-match mode codes
`define TOCMP_RST_MATCH 16'h0000
`define TOCMP_RST_MODE 4'h0
`define TOCMP_RST_ACT 2'h0
`define TOCMP_MODE_CTC_A 4'h4
`define TOCMP_MODE_CTC_ICR 4'hc
`endif

// ==== inc/tocmp_pkg.sv ====
// Types shared by the timer output compare channel
package tocmp_pkg;
  // ========================================================================
  // Output action selection codes
  typedef enum logic [1:0] {
    tocmp_act_none = 2'h0,
    tocmp_act_toggle = 2'h1,
    tocmp_act_clear = 2'h2,
    tocmp_act_set = 2'h3
  } tocmp_act_t;
  // ========================================================================
  // Write pairing state of the high-byte staging latch, one-hot
  typedef enum logic [1:0] {
    tocmp_wr_idle = 2'b01,
    tocmp_wr_staged = 2'b10
  } tocmp_wr_t;
endpackage

// ==== test/tocmp_monitor.sv ====
// Port checker of the output compare channel, with its bind
`timescale 1ns/1ps
module tocmp_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] timer_count,
  input wire logic timer_tick,
  input wire logic count_write,
  input wire logic irq_ack,
  input wire logic irq,
  input wire logic match_top,
  input wire logic match_top_en,
  input wire logic waveform_out_state,
  input wire logic pin_out,
  input wire logic pin_oe
);
  // ====================================================================
  // Decode; writes with clk_en low are ignored, so these only widen
  wire wr = psel && penable && pwrite;
  wire ctrl_wr = wr && paddr == 12'h000;
  wire mapd = paddr <= 12'h018 && paddr[1:0] == 2'h0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ====================================================================
  // Properties
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (pslverr == (psel && penable && !mapd))
    else $error("pslverr wrong");
  a_match_steady: assert property ($stable(timer_count) &&
    !$past(wr) && !$past(timer_tick) && !$past(count_write) |->
    $stable(match_top))
    else $error("match moved alone");
  a_out_cause: assert property ($changed(waveform_out_state) |->
    $past(timer_tick) || $past(wr))
    else $error("output moved alone");
  a_irq_rise: assert property ($rose(irq) |->
    $past(timer_tick) || $past(wr))
    else $error("irq rose alone");
  a_irq_fall: assert property ($fell(irq) |->
    $past(irq_ack) || $past(wr))
    else $error("irq fell alone");
  a_ack_clears: assert property (irq && irq_ack && !timer_tick |=>
    !irq)
    else $error("ack kept irq");
  a_dir_hold: assert property ($changed(pin_oe) |-> $past(ctrl_wr))
    else $error("pin_oe moved alone");
  a_pin_source: assert property ($changed(pin_out) |->
    $changed(waveform_out_state) || $past(ctrl_wr))
    else $error("pin_out moved alone");
  a_top_hold: assert property ($changed(match_top_en) |->
    $past(ctrl_wr))
    else $error("top source moved");
  a_reset_out: assert property (disable iff (1'h0) !presetn |->
    !waveform_out_state)
    else $error("output set in reset");
  // Main scenarios
  c_irq: cover property ($rose(irq));
  c_ack: cover property (irq && irq_ack);
  c_pin: cover property ($changed(pin_out));
endmodule
bind tocmp_channel tocmp_monitor u_mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .timer_count, .timer_tick, .irq_ack,
  .count_write, .irq, .match_top, .match_top_en, .waveform_out_state,
  .pin_out, .pin_oe);

// ==== test/tocmp_channel_test.sv ====
// Self-checking bench of the output compare channel
`timescale 1ns/1ps
module tocmp_channel_test;
  // ====================================================================
  // Stimulus and observed signals
  logic pclk = 1'h0;
  logic presetn;
  logic clk_en = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] timer_count = 16'h0;
  logic timer_tick = 1'h0;
  logic count_write = 1'h0;
  logic at_top = 1'h0;
  logic at_bottom = 1'h0;
  logic count_down = 1'h0; // Up-counting only
  logic irq_ack = 1'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err_seen, irq, match_top, match_top_en;
  logic waveform_out_state, pin_out, pin_oe, o;
  logic [15:0] v;
  logic [1:0] ac;
  int error_cnt = 0;
  int cmp_count = 0;
  bit hung = 1'b0;
  tocmp_channel dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_count, .timer_tick,
    .count_write, .at_top, .at_bottom, .count_down, .irq_ack, .irq,
    .match_top, .match_top_en, .waveform_out_state, .pin_out, .pin_oe);
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  // ====================================================================
  // Helpers; all checks happen at the falling edge, after updates land
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out(input bit hung);
    if (hung) error_cnt++;
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) hung = 1'b1;
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge pclk);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // One timer clock with the count and TOP/BOTTOM levels held across it
  task automatic tk(input logic [15:0] c, input logic [1:0] tb);
    @(posedge pclk);
    timer_count <= c;
    {at_top, at_bottom} <= tb;
    timer_tick <= 1'h1;
    @(posedge pclk);
    timer_tick <= 1'h0;
    {at_top, at_bottom} <= 2'h0;
    @(negedge pclk);
  endtask
  function automatic logic nx(input logic [1:0] a, input logic c);
    case (a)
      2'h0: nx = c;
      2'h1: nx = ~c;
      2'h2: nx = 1'h0;
      default: nx = 1'h1;
    endcase
  endfunction
  function automatic logic [31:0] cw(input logic [3:0] m,
                                     input logic [1:0] a, input logic [3:0] f);
    cw = {22'h0, f, a, m};
  endfunction
  // ====================================================================
  // Main sequence
  initial begin
    void'($urandom(95707));
    presetn <= 1'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rdchk("ctrl", 12'h000, 32'h0);
    chk("out", waveform_out_state, 1'h0);
    chk("oe", pin_oe, 1'h0);
    apb(1'h0, 12'h01c, 32'h0);
    chk("err", err_seen, 1'h1);
    apb(1'h1, 12'h008, 32'h5a);
    rdchk("low", 12'h014, 32'h5a);
    // Direct and buffered paths: mode 14 loads at BOTTOM, mode 8 at TOP
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, 12'h000, cw(i[1] ? 4'h8 : (i[0] ? 4'he : 4'h0), 2'h0, 4'h0));
      rdchk("hold", 12'h014, i ? {16'h0, v} : 32'h5a);
      v = 16'($urandom);
      apb(1'h1, 12'h004, {24'h0, v[15:8]});
      apb(1'h1, 12'h008, {24'h0, v[7:0]});
      if (i > 0) begin
        rdchk("buf", 12'h018, v);
        tk(v + 16'h1, i[1] ? 2'h2 : 2'h1);
      end
      rdchk("act", 12'h014, v);
    end
    // Matches with every action, flag cleared by service or by W1C
    o = 1'h0;
    for (int i = 0; i < 8; i++) begin
      ac = 2'($urandom);
      if (i < 4) ac = i[1:0];
      apb(1'h1, 12'h000, cw(4'h0, ac, {2'h1, i[1], 1'h1}));
      tk(v, 2'h0);
      chk("raw", match_top, 1'h1);
      chk("early", irq, 1'h0);
      tk(v + 16'h1, 2'h0);
      o = nx(ac, o);
      chk("out", waveform_out_state, o);
      chk("pin", pin_out, ac != 2'h0 ? o : i[1]);
      chk("irq", irq, 1'h1);
      if (i[0]) begin
        @(posedge pclk);
        irq_ack <= 1'h1;
        @(posedge pclk);
        irq_ack <= 1'h0;
        @(negedge pclk);
        chk("ack", irq, 1'h0);
      end else begin
        apb(1'h1, 12'h00c, 32'h0);
        chk("w0", irq, 1'h1);
        apb(1'h1, 12'h00c, 32'h1);
        chk("w1c", irq, 1'h0);
      end
    end
    // Forced matches move the output but never the flag
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, 12'h000, cw(4'h0, i[1:0], 4'h5));
      apb(1'h1, 12'h010, 32'h1);
      o = nx(i[1:0], o);
      chk("force", waveform_out_state, o);
      chk("noflag", irq, 1'h0);
    end
    rdchk("frd", 12'h010, 32'h0);
    // Counter write hides the next tick's match
    @(posedge pclk);
    count_write <= 1'h1; // Non-PWM mode, no TOP hazard
    @(posedge pclk);
    count_write <= 1'h0;
    tk(v, 2'h0);
    tk(v + 16'h1, 2'h0);
    chk("block", irq, 1'h0);
    // clk_en low freezes all state, a toggling match included
    apb(1'h1, 12'h000, cw(4'h0, 2'h1, 4'h5));
    @(posedge pclk);
    clk_en <= 1'h0;
    tk(v, 2'h0);
    tk(v + 16'h1, 2'h0);
    @(posedge pclk);
    clk_en <= 1'h1;
    @(negedge pclk);
    chk("frz", waveform_out_state, o);
    chk("frzirq", irq, 1'h0);
    // Fast PWM: clear on match, set at BOTTOM, and the inverse
    apb(1'h1, 12'h000, cw(4'he, 2'h2, 4'h4));
    tk(16'h0, 2'h1);
    chk("bot", waveform_out_state, 1'h1);
    tk(v, 2'h0);
    tk(v + 16'h1, 2'h0);
    chk("pclr", waveform_out_state, 1'h0);
    apb(1'h1, 12'h000, cw(4'he, 2'h3, 4'h4));
    tk(v, 2'h0);
    tk(v + 16'h1, 2'h0);
    chk("pset", waveform_out_state, 1'h1);
    apb(1'h1, 12'h010, 32'h1);
    chk("pfrc", waveform_out_state, 1'h1);
    apb(1'h1, 12'h000, cw(4'h0, 2'h0, 4'hc));
    chk("keep", waveform_out_state, 1'h1);
    chk("topen", match_top_en, 1'h1);
    apb(1'h1, 12'h000, cw(4'he, 2'h3, 4'h4));
    tk(16'h0, 2'h1);
    chk("pbot", waveform_out_state, 1'h0);
    apb(1'h1, 12'h010, 32'h1);
    chk("pfrc0", waveform_out_state, 1'h0);
    apb(1'h1, 12'h000, cw(4'h0, 2'h0, 4'h0));
    chk("dir", pin_oe, 1'h0);
    close_out(hung);
  end
endmodule
